/* File: hw/cbtaf_top.sv */
// CAN bit timing configuration and 32-way receive acceptance filtering.
// Assumes an AXI4-Lite master on core_clk; received identifiers and the
// bus level arrive synchronous to core_clk from the protocol engine.
//
// Summary of operation
// RULE_01: Propagation segment is field plus one quanta.
// RULE_02: Jump width codes give one to four quanta.
// RULE_03: Quantum lasts two times prescaler plus one clocks.
// RULE_04: Phase two automatic unless programmable flag set.
// RULE_05: No triple sampling with prescaler below two; the code takes three samples whenever the flag is set, at any prescaler.
// RULE_06: Software keeps quanta per bit above seven.
// RULE_07: Timing writes only in configuration mode.
// RULE_08: Thirty-two filters each with own identifier register.
// RULE_09: Standard identifier bits must all match.
// RULE_10: Type bit selects extended or standard messages.
// RULE_11: Extended identifier bits must all match.
// RULE_12: Filter identifier writable only while disabled.
// RULE_13: Unimplemented filter bits twenty, eighteen read zero.
// RULE_14: Software keeps jump width within phase two.
// RULE_15: Bit is sync, propagation, phase one, phase two.
`timescale 1ns/10ps
module cbtaf_top #(
    parameter int NUM = cbtaf_pkg::NUM_FILTERS
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [cbtaf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cbtaf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bus level and received identifier from the protocol engine
    input wire logic rx_bit,
    input wire logic rx_valid,
    input wire logic rx_is_extended,
    input wire logic [10:0] rx_std_id,
    input wire logic [17:0] rx_ext_id,
    // Results
    output logic accept_valid,
    output logic accept_hit,
    output logic [4:0] accept_index,
    output logic tq_tick,
    output logic bit_start,
    output logic sample_point,
    output logic sampled_bit
);
    import cbtaf_pkg::*;

    // ==========
    // Elaboration check
    if (NUM < 1 || NUM > 32) begin : g_bad_num
        $error("cbtaf_top: NUM must be 1 to 32");
    end

    // ==========
    // Registers
    logic [31:0] control_reg;
    logic [31:0] timing_reg;
    logic [NUM-1:0] filter_enable_bit;
    logic [31:0] filter_id [NUM]; // RULE_08
    logic [NUM*32-1:0] filter_flat;
    logic [NUM-1:0] hit;
    logic [4:0] quanta_per_bit;
    logic [31:0] read_word;
    logic read_ok;

    // ==========
    // Byte-lane merge used by every register write
    function automatic logic [31:0] merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] lane;
        lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old_val & ~lane) | (new_val & lane);
    endfunction

    // Lowest matching filter wins
    function automatic logic [4:0] first_hit(input logic [NUM-1:0] v);
        first_hit = 5'd0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_hit = i[4:0];
            end
        end
    endfunction

    // ==========
    // Field decode
    wire logic [2:0] operating_mode_field = control_reg[MODE_LSB +: 3];
    wire logic config_mode = operating_mode_field == MODE_CONFIG;
    wire logic [5:0] quantum_prescaler = timing_reg[PRESC_LSB +: 6];
    wire logic [1:0] resync_jump_width = timing_reg[SJW_LSB +: 2];
    wire logic [2:0] propagation_segment_len = timing_reg[PROP_LSB +: 3];
    wire logic [2:0] phase_one_len = timing_reg[PH1_LSB +: 3];
    wire logic three_sample = timing_reg[THREE_SAMPLE_BIT];
    wire logic phase_two_programmable = timing_reg[PH2_PROG_BIT];
    wire logic [2:0] phase_two_prog_len = timing_reg[PH2_LSB +: 3];
    // Automatic phase two equals phase one, the longest that still respects seg2 <= seg1
    wire logic [2:0] phase_two_len = phase_two_programmable ?
                                     phase_two_prog_len : phase_one_len; // RULE_04

    // ==========
    // Write channel: both address and data seen, then one ready pulse
    wire logic wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    wire logic wr_start = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire logic [ADDR_W-1:0] waddr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    wire logic [ADDR_W-1:0] wfilt_off = waddr - OFF_FILTER_BASE;
    wire logic wr_is_filter = waddr >= OFF_FILTER_BASE &&
                              wfilt_off[ADDR_W-1:2] < NUM[ADDR_W-3:0];
    wire logic [4:0] wr_filter_index = wfilt_off[6:2];
    wire logic wr_control = wr_take && waddr == OFF_CONTROL;
    wire logic wr_timing = wr_take && waddr == OFF_BIT_TIMING;
    wire logic wr_enable = wr_take && waddr == OFF_FILTER_ENABLE;
    wire logic wr_filter = wr_take && wr_is_filter;
    wire logic wr_mapped = wr_control || wr_timing || wr_enable ||
                           (wr_take && waddr == OFF_STATUS) || wr_filter;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_start;
            s_axi_wready <= wr_start;
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control, timing and enable registers; timing locked outside configuration mode
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            control_reg <= CONTROL_RESET;
            timing_reg <= TIMING_RESET;
            filter_enable_bit <= '0;
        end else begin
            if (wr_control) begin
                control_reg <= merge(control_reg, s_axi_wdata, s_axi_wstrb, CONTROL_WMASK);
            end
            if (wr_timing && config_mode) begin // RULE_07
                timing_reg <= merge(timing_reg, s_axi_wdata, s_axi_wstrb, TIMING_WMASK);
            end
            if (wr_enable) begin
                filter_enable_bit <= NUM'(merge(32'(filter_enable_bit), s_axi_wdata,
                                                s_axi_wstrb, 32'hffff_ffff));
            end
        end
    end

    // Filter identifiers; a filter in use keeps its identifier, unused bits stay zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM; i++) begin
                filter_id[i] <= FILTER_RESET;
            end
        end else if (wr_filter && !filter_enable_bit[wr_filter_index]) begin // RULE_12
            filter_id[wr_filter_index] <= merge(filter_id[wr_filter_index], s_axi_wdata,
                                                s_axi_wstrb, FILTER_WMASK); // RULE_13
        end
    end

    // ==========
    // Read channel: address taken with a ready pulse, data the cycle after
    wire logic rd_start = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    wire logic [ADDR_W-1:0] raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire logic [ADDR_W-1:0] rfilt_off = raddr - OFF_FILTER_BASE;
    wire logic rd_is_filter = raddr >= OFF_FILTER_BASE &&
                              rfilt_off[ADDR_W-1:2] < NUM[ADDR_W-3:0];
    wire logic [31:0] status_word = {16'h0000, 3'b000, quanta_per_bit,
                                     accept_hit, sampled_bit, 1'b0, accept_index};

    // Read decode
    always_comb begin
        read_word = 32'h0000_0000;
        read_ok = 1'b1;
        if (raddr == OFF_CONTROL) begin
            read_word = control_reg;
        end else if (raddr == OFF_BIT_TIMING) begin
            read_word = timing_reg;
        end else if (raddr == OFF_FILTER_ENABLE) begin
            read_word = 32'(filter_enable_bit);
        end else if (raddr == OFF_STATUS) begin
            read_word = status_word;
        end else if (rd_is_filter) begin
            read_word = filter_id[rfilt_off[6:2]] & FILTER_WMASK; // RULE_13
        end else begin
            read_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_start;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========
    // Acceptance filtering
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            filter_flat[i*32 +: 32] = filter_id[i];
        end
    end

    cbtaf_filter_match #(
        .NUM(NUM)
    ) u_match (
        .filter_words(filter_flat),
        .filter_enable_bit(filter_enable_bit),
        .rx_is_extended(rx_is_extended),
        .rx_std_id(rx_std_id),
        .rx_ext_id(rx_ext_id),
        .hit(hit)
    );

    // One result per received identifier; held until the next one
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            accept_valid <= 1'b0;
            accept_hit <= 1'b0;
            accept_index <= 5'd0;
        end else begin
            accept_valid <= rx_valid;
            if (rx_valid) begin
                accept_hit <= |hit; // RULE_09
                accept_index <= first_hit(hit);
            end
        end
    end

    // ==========
    // Bit timing; stopped in configuration mode so half-written settings never run
    cbtaf_bit_timer u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(!config_mode),
        .prescaler(quantum_prescaler), // RULE_03
        .prop_code(propagation_segment_len), // RULE_01
        .ph1_code(phase_one_len),
        .ph2_code(phase_two_len), // RULE_04
        .sjw_code(resync_jump_width), // RULE_02
        .three_sample(three_sample), // RULE_05
        .rx_bit(rx_bit),
        .tq_tick(tq_tick),
        .bit_start(bit_start),
        .sample_point(sample_point), // RULE_15
        .sampled_bit(sampled_bit),
        .quanta_per_bit(quanta_per_bit) // RULE_06
    );
endmodule // cbtaf_top

/* File: hw/cbtaf_pkg.sv */
// Constants, field layouts and types shared by the bit timing and filter block.
// Assumes a 32-bit register word and one system clock for all logic.
package cbtaf_pkg;
    // ==========
    // Clock and sizes
    localparam int SYSTEM_CLOCK_FREQ = 25_000_000;
    localparam int NUM_FILTERS = 32;
    localparam int ADDR_W = 8;
    // ==========
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_BIT_TIMING = 8'h04;
    localparam logic [7:0] OFF_FILTER_ENABLE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_FILTER_BASE = 8'h80;
    // ==========
    // Control register: operating mode field
    localparam int MODE_LSB = 21;
    localparam logic [2:0] MODE_CONFIG = 3'b100;
    localparam logic [31:0] CONTROL_RESET = 32'h0080_0000;
    localparam logic [31:0] CONTROL_WMASK = 32'h00e0_0000;
    // ==========
    // Bit timing register fields
    localparam int PRESC_LSB = 0;
    localparam int SJW_LSB = 6;
    localparam int PROP_LSB = 8;
    localparam int PH1_LSB = 11;
    localparam int THREE_SAMPLE_BIT = 14;
    localparam int PH2_PROG_BIT = 15;
    localparam int PH2_LSB = 16;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMING_WMASK = 32'h0007_ffff;
    // ==========
    // Acceptance filter identifier register fields
    localparam int STD_ID_LSB = 21;
    localparam int EXT_SELECT_BIT = 19;
    localparam int EXT_ID_LSB = 0;
    localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
    localparam logic [31:0] FILTER_WMASK = 32'hffeb_ffff;
    // ==========
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ==========
    // Bit time segments
    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_PROP = 2'b01,
        SEG_PH1 = 2'b10,
        SEG_PH2 = 2'b11
    } cbtaf_seg_type;

    // Code n of a length field means n+1 quanta
    function automatic logic [3:0] cbtaf_quanta_len(input logic [2:0] code);
        cbtaf_quanta_len = {1'b0, code} + 4'h1;
    endfunction
endpackage

/* File: hw/cbtaf_filter_match.sv */
// Compares one received identifier against every acceptance filter at once.
// Assumes identifiers stay stable while rx_valid is high; output is combinational.
`timescale 1ns/10ps
module cbtaf_filter_match #(
    parameter int NUM = 32
) (
    input wire logic [NUM*32-1:0] filter_words,
    input wire logic [NUM-1:0] filter_enable_bit,
    input wire logic rx_is_extended,
    input wire logic [10:0] rx_std_id,
    input wire logic [17:0] rx_ext_id,
    output logic [NUM-1:0] hit
);
    import cbtaf_pkg::*;

    // ==========
    // Elaboration check
    if (NUM < 1 || NUM > 32) begin : g_bad_num
        $error("cbtaf_filter_match: NUM must be 1 to 32");
    end

    // One comparator per filter; a disabled filter never hits
    for (genvar i = 0; i < NUM; i++) begin : g_flt
        wire logic [31:0] w = filter_words[i*32 +: 32];
        wire logic std_eq = w[STD_ID_LSB +: 11] == rx_std_id; // RULE_09
        wire logic type_eq = w[EXT_SELECT_BIT] == rx_is_extended; // RULE_10
        wire logic ext_eq = !rx_is_extended || (w[EXT_ID_LSB +: 18] == rx_ext_id); // RULE_11
        assign hit[i] = filter_enable_bit[i] && std_eq && type_eq && ext_eq;
    end
endmodule // cbtaf_filter_match

/* File: hw/cbtaf_bit_timer.sv */
// Time quantum prescaler and nominal bit time sequencer with sample point.
// Assumes rx_bit is already synchronous to core_clk; settings held while run.
`timescale 1ns/10ps
module cbtaf_bit_timer (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [5:0] prescaler,
    input wire logic [2:0] prop_code,
    input wire logic [2:0] ph1_code,
    input wire logic [2:0] ph2_code,
    input wire logic [1:0] sjw_code,
    input wire logic three_sample,
    input wire logic rx_bit,
    output logic tq_tick,
    output logic bit_start,
    output logic sample_point,
    output logic sampled_bit,
    output logic [4:0] quanta_per_bit
);
    import cbtaf_pkg::*;

    logic [6:0] presc_cnt;
    cbtaf_seg_type seg;
    logic [3:0] q_cnt;
    logic [3:0] ph1_ext;
    logic ph2_cut;
    logic rx_prev;
    logic [1:0] hist;

    // ==========
    // Decode of lengths and segment ends
    wire logic [3:0] prop_len = cbtaf_quanta_len(prop_code); // RULE_01
    wire logic [3:0] ph1_len = cbtaf_quanta_len(ph1_code);
    wire logic [3:0] ph2_len = cbtaf_quanta_len(ph2_code);
    wire logic [3:0] sjw_len = {2'b00, sjw_code} + 4'h1; // RULE_02
    wire logic [6:0] presc_last = {prescaler, 1'b1}; // RULE_03
    wire logic tq_end = run && (presc_cnt == presc_last);
    wire logic [4:0] ph1_total = {1'b0, ph1_len} + {1'b0, ph1_ext};
    wire logic [4:0] seg_len = (seg == SEG_SYNC) ? 5'd1 :
                               (seg == SEG_PROP) ? {1'b0, prop_len} :
                               (seg == SEG_PH1) ? ph1_total : {1'b0, ph2_len};
    wire logic seg_last = ({1'b0, q_cnt} + 5'd1) >= seg_len;
    wire logic seg_done = tq_end && (seg_last || (seg == SEG_PH2 && ph2_cut));
    wire logic fall_edge = run && rx_prev && !rx_bit;
    wire logic [3:0] ph2_left = ph2_len - q_cnt;
    wire logic majority = (hist[0] & hist[1]) | (hist[0] & rx_bit) | (hist[1] & rx_bit);
    wire logic sample_now = seg_done && seg == SEG_PH1; // RULE_15

    // Prescaler: a quantum is 2*(code+1) clocks
    always_ff @(posedge core_clk) begin
        if (!rst_b || !run || tq_end) begin
            presc_cnt <= 7'h00;
        end else begin
            presc_cnt <= presc_cnt + 7'h01;
        end
    end

    // Segment sequencer: sync, propagation, phase 1, phase 2
    always_ff @(posedge core_clk) begin
        if (!rst_b || !run) begin
            seg <= SEG_SYNC;
            q_cnt <= 4'h0;
        end else if (seg_done) begin
            q_cnt <= 4'h0;
            case (seg)
                SEG_SYNC: seg <= SEG_PROP;
                SEG_PROP: seg <= SEG_PH1;
                SEG_PH1: seg <= SEG_PH2;
                default: seg <= SEG_SYNC;
            endcase // RULE_15
        end else if (tq_end) begin
            q_cnt <= q_cnt + 4'h1;
        end
    end

    // Resync: late edge stretches phase 1, early edge cuts phase 2 by at most the jump width
    always_ff @(posedge core_clk) begin
        if (!rst_b || !run || (seg_done && seg != SEG_PROP)) begin
            ph1_ext <= 4'h0;
            ph2_cut <= 1'b0;
        end else if (fall_edge && (seg == SEG_PROP || seg == SEG_PH1)) begin
            ph1_ext <= sjw_len; // RULE_02
        end else if (fall_edge && seg == SEG_PH2 && ph2_left <= sjw_len) begin
            ph2_cut <= 1'b1;
        end
    end

    // Bus history and registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_prev <= 1'b1;
            hist <= 2'b11;
            tq_tick <= 1'b0;
            bit_start <= 1'b0;
            sample_point <= 1'b0;
            sampled_bit <= 1'b1;
            quanta_per_bit <= 5'd0;
        end else begin
            rx_prev <= rx_bit;
            if (tq_end) begin
                hist <= {hist[0], rx_bit};
            end
            tq_tick <= tq_end;
            bit_start <= seg_done && seg == SEG_PH2;
            sample_point <= sample_now;
            if (sample_now) begin
                sampled_bit <= three_sample ? majority : rx_bit;
            end
            quanta_per_bit <= 5'd1 + {1'b0, prop_len} + {1'b0, ph1_len} + {1'b0, ph2_len};
        end
    end
endmodule // cbtaf_bit_timer

/* File: verif/cbtaf_sva.sv */
// Port checker for the CAN bit timing and acceptance filter block.
// Assumes one clock domain; bound onto cbtaf_top after the module.
`timescale 1ns/10ps
module cbtaf_sva (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic rx_valid,
    input wire logic accept_valid,
    input wire logic tq_tick,
    input wire logic bit_start,
    input wire logic sample_point
);
    // ==========
    // Register bus steps
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr_offer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    endsequence
    sequence s_wr_take;
        s_axi_awready && s_axi_wready;
    endsequence
    property p_wr_take; s_wr_offer |-> ##[1:2] s_wr_take; endproperty
    a_wr_take: assert property (p_wr_take)
        else $error("write offer not taken");
    property p_wr_pair; s_axi_awready |-> s_axi_wready; endproperty
    a_wr_pair: assert property (p_wr_pair)
        else $error("address and data ready apart");
    property p_wr_resp; s_wr_take |=> s_axi_bvalid && !s_axi_awready; endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("no write response");
    property p_rd_take;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |-> ##[1:2] s_axi_arready;
    endproperty
    a_rd_take: assert property (p_rd_take)
        else $error("read not taken");
    property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("no read data");
    // ==========
    // Filter answer and bit timing
    property p_acc; rx_valid |=> accept_valid; endproperty
    a_acc: assert property (p_acc)
        else $error("identifier got no answer");
    property p_acc_src; accept_valid |-> $past(rx_valid); endproperty
    a_acc_src: assert property (p_acc_src)
        else $error("answer without identifier");
    // Quantum is at least two clocks, so ticks never touch
    property p_tq_gap; tq_tick |=> !tq_tick; endproperty
    a_tq_gap: assert property (p_tq_gap)
        else $error("quantum shorter than two clocks");
    property p_sp_tick; sample_point |-> tq_tick && !bit_start; endproperty
    a_sp_tick: assert property (p_sp_tick)
        else $error("sample point off a quantum end");
endmodule // cbtaf_sva

bind cbtaf_top cbtaf_sva i_cbtaf_sva (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .rx_valid(rx_valid),
    .accept_valid(accept_valid), .tq_tick(tq_tick), .bit_start(bit_start),
    .sample_point(sample_point));

/* File: verif/cbtaf_can_node.sv */
// Far side CAN node seen through the transceiver: drives the bus level.
// Assumes bit_start from the block; recessive from the next bit start once not sending.
`timescale 1ns/10ps
module cbtaf_can_node (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bit_start,
    input wire logic send,
    output logic rx_bit
);
    // ==========
    // New level just after each bit start, so edges land in sync quantum
    logic [7:0] pat;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pat <= 8'h4d;
            rx_bit <= 1'b1;
        end else if (bit_start) begin
            rx_bit <= send ? pat[0] : 1'b1;
            pat <= {pat[0], pat[7:1]};
        end
    end
endmodule // cbtaf_can_node

/* File: verif/cbtaf_top_bench.sv */
// Self-checking bench for cbtaf_top: register bus, filters, bit timer.
// Assumes the package constants; far-side node in its own module.
`timescale 1ns/10ps
module cbtaf_top_bench;
import cbtaf_pkg::*;
logic clk, rst_b, awv, wv, bre, arv, rre, rxv, rxe, send, sp_d;
logic [7:0] awa, ara;
logic [31:0] wd, en;
logic [3:0] ws;
logic [10:0] standard_identifier_bits;
logic [17:0] extended_identifier_bits;
wire logic awr, wrd, bv, arr, rv, av, ah, tq, bs, sp, sb, rxb;
wire logic [1:0] br, rr;
wire logic [31:0] rdat;
wire logic [4:0] ai;
logic [31:0] flt [32];
logic [33:0] q_r[$];
logic [1:0] q_b[$];
logic [5:0] q_a[$];
int err_count, n_compared, cyc;
cbtaf_top i_cbtaf_top (.core_clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .rx_bit(rxb), .rx_valid(rxv), .rx_is_extended(rxe), .rx_std_id(standard_identifier_bits),
    .rx_ext_id(extended_identifier_bits), .accept_valid(av), .accept_hit(ah), .accept_index(ai),
    .tq_tick(tq), .bit_start(bs), .sample_point(sp), .sampled_bit(sb));
cbtaf_can_node i_cbtaf_can_node (.core_clk(clk), .rst_b(rst_b), .bit_start(bs),
    .send(send), .rx_bit(rxb));
// ==========
// Clock, timeout and result checks
initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end
task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    n_compared++;
    if (s !== e) begin
        err_count++;
        $display("ERROR %s expected %h seen %h", nm, e, s);
    end
endtask
// Hang guard well above the eleven hundred or so cycles the run needs
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        err_count++;
        results();
    end
end
// Oldest note is taken off whenever the block answers
always @(posedge clk) begin
    sp_d <= sp;
    if (rst_b) begin
        if (bv && bre) chk("bresp", br, q_b.pop_front());
        if (rv && rre) chk("rdata", {rr, rdat}, q_r.pop_front());
        if (av) chk("accept", {ah, ai}, q_a.pop_front());
        if (sp_d && send) chk("sampled", sb, rxb);
    end
end
// ==========
// Bus tasks; one idle edge at the end keeps drivers from double assignment
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q_b.push_back(r);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1);
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    bre <= 1'b0;
    @(posedge clk);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    q_r.push_back({r, e});
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rre <= 1'b0;
    @(posedge clk);
endtask
// Expected answer from the bench's own copy of filters and enables
task automatic rxs(input logic x, input logic [10:0] s, input logic [17:0] e);
    logic [5:0] ex;
    ex = 6'h00;
    for (int n = 31; n >= 0; n--)
        if (en[n] && flt[n][31:21] == s && flt[n][19] == x && (!x || flt[n][17:0] == e))
            ex = {1'b1, 5'(n)};
    q_a.push_back(ex);
    rxv <= 1'b1; rxe <= x; standard_identifier_bits <= s; extended_identifier_bits <= e;
    @(posedge clk);
endtask
task automatic meas(input int eb, input int eq);
    int c;
    repeat (2) do @(posedge clk); while (bs !== 1'b1);
    c = 0;
    do begin @(posedge clk); c++; end while (bs !== 1'b1);
    chk("bit clocks", c, eb);
    do @(posedge clk); while (tq !== 1'b1);
    c = 0;
    do begin @(posedge clk); c++; end while (tq !== 1'b1);
    chk("quantum clocks", c, eq);
endtask
// ==========
// Main sequence
initial begin
    int n, m;
    logic [31:0] v;
    {rst_b, awv, wv, bre, arv, rre, rxv, rxe, send} = '0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'hf; standard_identifier_bits = 11'h0; extended_identifier_bits = 18'h0; en = 32'h0;
    err_count = 0; n_compared = 0; cyc = 0;
    void'($urandom(51));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFF_CONTROL, CONTROL_RESET, RESP_OKAY);
    rd(OFF_FILTER_BASE, FILTER_RESET, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_BIT_TIMING, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_BIT_TIMING, TIMING_WMASK, RESP_OKAY);
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
    wr(OFF_BIT_TIMING, 32'h1100, RESP_OKAY);
    rd(OFF_BIT_TIMING, TIMING_WMASK, RESP_OKAY);
    // Automatic phase two, then programmed with triple sampling: 9 and 8 quanta
    for (int k = 0; k < 2; k++) begin
        wr(OFF_CONTROL, CONTROL_RESET, RESP_OKAY);
        wr(OFF_BIT_TIMING, k ? 32'h1_d802 : 32'h1100, RESP_OKAY);
        wr(OFF_CONTROL, 32'h0, RESP_OKAY);
        meas(k ? 48 : 18, k ? 6 : 2);
    end
    send <= 1'b1;
    repeat (400) @(posedge clk);
    send <= 1'b0;
    for (n = 0; n < 32; n++) begin
        v = $urandom;
        flt[n] = v & FILTER_WMASK;
        wr(OFF_FILTER_BASE + 8'(4 * n), v, RESP_OKAY);
        rd(OFF_FILTER_BASE + 8'(4 * n), flt[n], RESP_OKAY);
    end
    en = $urandom;
    wr(OFF_FILTER_ENABLE, en, RESP_OKAY);
    for (n = 0; n < 8; n++) begin
        v = $urandom;
        wr(OFF_FILTER_BASE + 8'(4 * n), v, RESP_OKAY);
        if (!en[n]) flt[n] = v & FILTER_WMASK;
        rd(OFF_FILTER_BASE + 8'(4 * n), flt[n], RESP_OKAY);
    end
    // Copies, random and type-flipped identifiers, back to back
    for (int k = 0; k < 60; k++) begin
        n = $urandom % 32;
        m = $urandom % 3;
        rxs(m == 1 ? 1'($urandom) : flt[n][19] ^ (m == 2),
            m == 1 ? 11'($urandom) : flt[n][31:21], m == 1 ? 18'($urandom) : flt[n][17:0]);
    end
    rxv <= 1'b0;
    repeat (3) @(posedge clk);
    results();
end
endmodule // cbtaf_top_bench
